// ### rtl/chan_regs_cfg.svh
/*
  Register offsets, field positions and reset values of the channel
  select register bank.
  Assumes it is included by its bare name from the modules.
*/
// How it works
// - Read-only 16-bit signature word, writes ignored
// - Bit 15 enables channel, resets to one
// - Several enabled channels are stepped through automatically
// - Bits 13:12 choose one of four setups
// - A setup is four registers applied together
// - Bits 9:5 pick positive input, reset input 0
// - Channel register at 0x10, 16 bits, reset 0x8001
// - Bits 4:0 pick negative input, reset code 00001
`ifndef CHAN_REGS_CFG_SVH
`define CHAN_REGS_CFG_SVH
`define ADDR_PART_SIGNATURE  8'h07
`define ADDR_CHANNEL_CONFIG0 8'h10
`define SIGNATURE_VALUE      16'h00a5
`define CH_RESET_VALUE       16'h8001
`define CH_WRITABLE_MASK     16'hb3ff
`define CH_EN_POS            15
`define SETUP_HI             13
`define SETUP_LO             12
`define POS_HI               9
`define POS_LO               5
`define NEG_HI               4
`define NEG_LO               0
`define SUPPLY_POS_CODE      5'h13
`define SUPPLY_NEG_CODE      5'h14
`define NUM_CHANNELS         4
`endif

// ### rtl/chan_regs_pkg.sv
/*
  Types of the channel select register bank.
  Assumes the constants header sits beside it.
*/
package chan_regs_pkg;
  // Decoded fields of one channel register
  typedef struct packed {
    logic       enable;   // Channel takes part in the scan
    logic [1:0] setup;    // Setup number 0 to 3
    logic [4:0] pos_sel;  // Positive input code
    logic [4:0] neg_sel;  // Negative input code
  } channel_fields_t;

  // Register-side read port
  typedef struct packed {
    logic        valid;   // Read answer strobe
    logic        hit;     // Address was mapped
    logic [15:0] data;    // Read data
  } read_answer_t;

  // Sequencer states, gray coded along the scan path
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_NEXT = 2'b11
  } seq_state_t;
endpackage : chan_regs_pkg

// ### rtl/channel_scanner.sv
/*
  Steps a pointer across the enabled channels, one step per done pulse.
  Assumes enables and done come from logic on the same clock.
*/
`include "chan_regs_cfg.svh"
module channel_scanner (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Channel enables and conversion done pulse
  input  wire logic [3:0] enables,
  input  wire logic       done,
  // Current channel and scanning flag
  output logic      [1:0] current,
  output logic            active
);
  // Whole state of the scanner
  typedef struct packed {
    chan_regs_pkg::seq_state_t st;
    logic [1:0]                ptr;
  } scan_t;

  scan_t s;       // Registered state
  scan_t next_s;  // Next state

  // Next enabled channel after the given one, wrapping round
  function automatic logic [1:0] next_enabled(input logic [1:0] from,
                                               input logic [3:0] en);
    logic [1:0] cand;
    logic [1:0] pick;
    pick = from;
    for (int i = 3; i >= 1; i--) begin
      cand = from + 2'(i);
      if (en[cand]) begin
        pick = cand;
      end
    end
    return pick;
  endfunction : next_enabled

  // Move on only when a conversion ends, so the analog path settles
  always_comb begin
    next_s = s;
    unique case (s.st)
      chan_regs_pkg::SEQ_IDLE: begin
        if (enables != 4'h0) begin
          next_s.st  = chan_regs_pkg::SEQ_CONV;
          next_s.ptr = en_ok(s.ptr) ? s.ptr : next_enabled(s.ptr, enables);
        end
      end
      chan_regs_pkg::SEQ_CONV: begin
        if (enables == 4'h0) begin
          next_s.st = chan_regs_pkg::SEQ_IDLE;
        end else if (done) begin
          next_s.st = chan_regs_pkg::SEQ_NEXT;
        end
      end
      chan_regs_pkg::SEQ_NEXT: begin
        next_s.ptr = next_enabled(s.ptr, enables);
        next_s.st  = (enables == 4'h0) ? chan_regs_pkg::SEQ_IDLE
                                       : chan_regs_pkg::SEQ_CONV;
      end
      default: next_s.st = chan_regs_pkg::SEQ_IDLE;
    endcase
  end

  // Pointer enable test
  function automatic logic en_ok(input logic [1:0] p);
    return enables[p];
  endfunction : en_ok

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '{st: chan_regs_pkg::SEQ_IDLE, ptr: 2'h0};
    end else begin
      s <= next_s;
    end
  end

  assign current = s.ptr;
  assign active  = (s.st != chan_regs_pkg::SEQ_IDLE);
endmodule : channel_scanner

// ### rtl/channel_select_regs.sv
/*
  Signature word and first channel configuration register, with the
  automatic channel scan pointer.
  Assumes the serial framing layer presents one-cycle read and write
  strobes with an 8-bit register address on CLOCK; the other three
  channel registers' enables arrive as plain same-clock inputs.
*/
`include "chan_regs_cfg.svh"
module channel_select_regs (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Register access from the serial framing layer
  input  wire logic [7:0]  ADDR,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  input  wire logic [15:0] WR_DATA,
  output logic             RD_VALID,
  output logic             RD_HIT,
  output logic      [15:0] RD_DATA,
  // Other channels and the converter core
  input  wire logic [2:0]  OTHER_ENABLES,
  input  wire logic        CONV_DONE,
  // Channel 0 fields towards the mux and setups
  output logic             CHANNEL_ENABLE,
  output logic      [1:0]  SETUP_SELECT,
  output logic      [4:0]  POS_INPUT_SELECT,
  output logic      [4:0]  NEG_INPUT_SELECT,
  output logic             SUPPLY_MONITOR_SEL,
  // Scan status
  output logic      [1:0]  CURRENT_CHANNEL,
  output logic             SCAN_ACTIVE,
  output logic             MULTI_CHANNEL
);
  // Whole state of the bank
  typedef struct packed {
    logic [15:0]                 ch0;    // Stored channel register
    chan_regs_pkg::read_answer_t rd;     // Registered read answer
    chan_regs_pkg::channel_fields_t f;   // Registered field outputs
    logic                        supply; // Supply monitor selected
    logic [1:0]                  cur;    // Registered scan pointer
    logic                        act;    // Registered scan flag
    logic                        multi;  // More than one channel on
  } bank_t;

  bank_t s;       // Registered state
  bank_t next_s;  // Next state

  logic [1:0] scan_cur;  // Scanner pointer
  logic       scan_act;  // Scanner running

  // Decode one channel word into fields, used for the field outputs
  function automatic chan_regs_pkg::channel_fields_t decode_ch(
      input logic [15:0] w);
    chan_regs_pkg::channel_fields_t r;
    r.enable  = w[`CH_EN_POS];
    r.setup   = w[`SETUP_HI:`SETUP_LO];
    r.pos_sel = w[`POS_HI:`POS_LO];
    r.neg_sel = w[`NEG_HI:`NEG_LO];
    return r;
  endfunction : decode_ch

  // Set when the count of enabled channels is above one
  function automatic logic several(input logic [3:0] en);
    return (en & (en - 4'h1)) != 4'h0;
  endfunction : several

  // Scan pointer across the four channel enables
  channel_scanner u_scan (
    .clock   (CLOCK),
    .rst     (RST),
    .enables ({OTHER_ENABLES, s.ch0[`CH_EN_POS]}),
    .done    (CONV_DONE),
    .current (scan_cur),
    .active  (scan_act)
  );

  // Writes land in channel 0 only; reserved bits stay zero
  always_comb begin
    next_s = s;
    next_s.rd.valid = 1'b0;
    if (WR_STB && ADDR == `ADDR_CHANNEL_CONFIG0) begin
      next_s.ch0 = WR_DATA & `CH_WRITABLE_MASK;
    end
    // Signature has no write path at all
    if (RD_STB) begin
      next_s.rd.valid = 1'b1;
      unique case (ADDR)
        `ADDR_PART_SIGNATURE: begin
          next_s.rd.hit  = 1'b1;
          next_s.rd.data = `SIGNATURE_VALUE;
        end
        `ADDR_CHANNEL_CONFIG0: begin
          next_s.rd.hit  = 1'b1;
          next_s.rd.data = s.ch0 & `CH_WRITABLE_MASK;
        end
        default: begin
          // Unmapped addresses answer zero and flag a miss
          next_s.rd.hit  = 1'b0;
          next_s.rd.data = 16'h0000;
        end
      endcase
    end
    next_s.f = decode_ch(s.ch0);
    // Flag only; buffer state lives elsewhere and is software's duty
    next_s.supply = (s.ch0[`POS_HI:`POS_LO] == `SUPPLY_POS_CODE) ||
                    (s.ch0[`POS_HI:`POS_LO] == `SUPPLY_NEG_CODE) ||
                    (s.ch0[`NEG_HI:`NEG_LO] == `SUPPLY_POS_CODE) ||
                    (s.ch0[`NEG_HI:`NEG_LO] == `SUPPLY_NEG_CODE);
    next_s.cur   = scan_cur;
    next_s.act   = scan_act;
    next_s.multi = several({OTHER_ENABLES, s.ch0[`CH_EN_POS]});
  end

  // State register with reset values
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s <= '{ch0: `CH_RESET_VALUE,
             rd: '{valid: 1'b0, hit: 1'b0, data: 16'h0000},
             f: '{enable: 1'b1, setup: 2'h0, pos_sel: 5'h00,
                  neg_sel: 5'h01},
             supply: 1'b0, cur: 2'h0, act: 1'b0, multi: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Every output straight from the state register
  assign RD_VALID           = s.rd.valid;
  assign RD_HIT             = s.rd.hit;
  assign RD_DATA            = s.rd.data;
  assign CHANNEL_ENABLE     = s.f.enable;
  assign SETUP_SELECT       = s.f.setup;
  assign POS_INPUT_SELECT   = s.f.pos_sel;
  assign NEG_INPUT_SELECT   = s.f.neg_sel;
  assign SUPPLY_MONITOR_SEL = s.supply;
  assign CURRENT_CHANNEL    = s.cur;
  assign SCAN_ACTIVE        = s.act;
  assign MULTI_CHANNEL      = s.multi;
endmodule : channel_select_regs

// ### testbench/channel_select_regs_sva.sv
/* Checker for the channel select register bank.
   Assumes it is bound to channel_select_regs on its single clock. */
`include "chan_regs_cfg.svh"
module channel_select_regs_sva (
  // Clock, reset and register bus
  input logic        CLOCK,
  input logic        RST,
  input logic [7:0]  ADDR,
  input logic        WR_STB,
  input logic        RD_STB,
  input logic [15:0] WR_DATA,
  input logic        RD_VALID,
  input logic        RD_HIT,
  input logic [15:0] RD_DATA,
  // Channel 0 fields
  input logic        CHANNEL_ENABLE,
  input logic [1:0]  SETUP_SELECT,
  input logic [4:0]  POS_INPUT_SELECT,
  input logic [4:0]  NEG_INPUT_SELECT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Fields land two cycles after the write is taken
  sequence ch_write;
    WR_STB && ADDR == `ADDR_CHANNEL_CONFIG0;
  endsequence
  sequence ch_read;
    RD_STB && ADDR == `ADDR_CHANNEL_CONFIG0;
  endsequence
  a_read_answer: assert property (
    RD_STB |=> RD_VALID) else $error("read not answered");
  a_signature_fixed: assert property (
    RD_STB && ADDR == `ADDR_PART_SIGNATURE |=>
    RD_HIT && RD_DATA == `SIGNATURE_VALUE) else $error("bad signature");
  a_reserved_zero: assert property (
    ch_read |=> RD_HIT && (RD_DATA & ~`CH_WRITABLE_MASK) == 16'h0000)
    else $error("reserved bits set");
  a_enable_write: assert property (
    ch_write |=> ##1 CHANNEL_ENABLE == $past(WR_DATA[15], 2))
    else $error("enable not updated");
  a_setup_write: assert property (
    ch_write |=> ##1 SETUP_SELECT == $past(WR_DATA[13:12], 2))
    else $error("setup not updated");
  a_pos_write: assert property (
    ch_write |=> ##1 POS_INPUT_SELECT == $past(WR_DATA[9:5], 2))
    else $error("positive input not updated");
  a_neg_write: assert property (
    ch_write |=> ##1 NEG_INPUT_SELECT == $past(WR_DATA[4:0], 2))
    else $error("negative input not updated");
  a_reset_fields: assert property (
    $fell(RST) |-> CHANNEL_ENABLE && SETUP_SELECT == 2'h0 &&
    POS_INPUT_SELECT == 5'h00 && NEG_INPUT_SELECT == 5'h01)
    else $error("bad reset fields");
endmodule : channel_select_regs_sva
bind channel_select_regs channel_select_regs_sva channel_select_regs_sva_inst (
  .CLOCK, .RST, .ADDR, .WR_STB, .RD_STB, .WR_DATA, .RD_VALID, .RD_HIT,
  .RD_DATA, .CHANNEL_ENABLE, .SETUP_SELECT, .POS_INPUT_SELECT,
  .NEG_INPUT_SELECT);

// ### testbench/tb_channel_select_regs.sv
/* Self-checking bench for the channel select register bank.
   Assumes the constants header; drives every port directly. */
`include "chan_regs_cfg.svh"
module tb_channel_select_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst = 1, wr_stb = 0, rd_stb = 0, conv_done = 0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wr_data = 16'h0000, rd_data, d;
  logic [2:0]  other_enables = 3'h0;
  logic        rd_valid, rd_hit, ch_en, sup, active, multi, h;
  logic [1:0]  setup, cur, c0;
  logic [4:0]  pos, neg;
  int          errors = 0, num_checks = 0, cycles = 0;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  channel_select_regs channel_select_regs_inst (
    .CLOCK(clock), .RST(rst), .ADDR(addr), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .WR_DATA(wr_data), .RD_VALID(rd_valid),
    .RD_HIT(rd_hit), .RD_DATA(rd_data), .OTHER_ENABLES(other_enables),
    .CONV_DONE(conv_done), .CHANNEL_ENABLE(ch_en), .SETUP_SELECT(setup),
    .POS_INPUT_SELECT(pos), .NEG_INPUT_SELECT(neg),
    .SUPPLY_MONITOR_SEL(sup), .CURRENT_CHANNEL(cur), .SCAN_ACTIVE(active),
    .MULTI_CHANNEL(multi));
  task chk(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so no race with sampling
  task tick;
    @(posedge clock);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [15:0] v);
    tick;
    wr_stb = 1;
    addr = a;
    wr_data = v;
    tick;
    wr_stb = 0;
  endtask : wr
  task rd(input logic [7:0] a);
    tick;
    rd_stb = 1;
    addr = a;
    tick;
    rd_stb = 0;
    chk(rd_valid, 1'b1);
    d = rd_data;
    h = rd_hit;
  endtask : rd
  task t_reset;
    rd(`ADDR_CHANNEL_CONFIG0);
    chk(d, 16'h8001);
    chk({ch_en, setup, pos, neg}, 16'h1001);
  endtask : t_reset
  // A write to the read-only word must not stick
  task t_signature;
    wr(`ADDR_PART_SIGNATURE, 16'hffff);
    rd(`ADDR_PART_SIGNATURE);
    chk(d, `SIGNATURE_VALUE);
    rd(8'h3f);
    chk({h, d[14:0]}, 16'h0000);
  endtask : t_signature
  task t_reserved;
    wr(`ADDR_CHANNEL_CONFIG0, 16'hffff);
    rd(`ADDR_CHANNEL_CONFIG0);
    chk(d, 16'hb3ff);
    chk({ch_en, setup, pos, neg}, 16'h1fff);
  endtask : t_reserved
  // Eleven input codes on both selectors, every setup code
  task t_codes;
    logic [4:0] c [11];
    c = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h11, 5'h12, 5'h13, 5'h14,
          5'h15, 5'h16};
    for (int i = 0; i < 11; i++) begin
      wr(`ADDR_CHANNEL_CONFIG0, {2'b00, i[1:0], 2'b00, c[i], c[10-i]});
      tick;
      chk({ch_en, setup, pos, neg}, {4'h0, i[1:0], c[i], c[10-i]});
      // Supply monitor codes on either selector raise the flag
      chk(sup, (c[i] == 5'h13) || (c[i] == 5'h14) ||
               (c[10-i] == 5'h13) || (c[10-i] == 5'h14));
    end
  endtask : t_codes
  // Two enabled channels: pointer alternates on each done pulse
  task t_scan;
    wr(`ADDR_CHANNEL_CONFIG0, 16'h8001);
    other_enables = 3'b010;
    repeat (4) tick;
    chk({active, multi}, 2'b11);
    conv_done = 1;
    tick;
    conv_done = 0;
    repeat (5) tick;
    c0 = cur;
    conv_done = 1;
    tick;
    conv_done = 0;
    repeat (5) tick;
    chk(c0 ^ cur, 2'b10);
    other_enables = 3'b000;
    repeat (3) tick;
    chk(multi, 1'b0);
  endtask : t_scan
  task complete_run;
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Hang guard, far above the roughly 70 cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    #1;
    rst = 0;
    t_reset;
    t_signature;
    t_reserved;
    t_codes;
    t_scan;
    complete_run;
  end
endmodule : tb_channel_select_regs
